// file: hw/fsr_pkg.sv
// Constants and types for the flash array and discoverable-parameter map
package fsr_pkg;

	// Main array organisation
	localparam int              ARR_AW       = 20;
	localparam int              BLK_LSB      = 16;
	localparam int              SEC_LSB      = 12;
	localparam int              PAGE_LSB     = 8;
	localparam logic [19:0]     BLK_MASK     = 20'h0ffff;
	localparam logic [19:0]     SEC_MASK     = 20'h00fff;
	localparam logic [19:0]     CHIP_MASK    = 20'hfffff;
	localparam logic [7:0]      ERASED       = 8'hff;

	// Security register space
	localparam int              SR_NUM       = 4;
	localparam int              SR_WORDS     = 768;
	localparam int              SR_SEL_LSB   = 12;
	localparam logic [7:0]      SR_LAST      = 8'hff;

	// Discoverable-parameter space layout
	localparam logic [7:0]      PRM_HDR_BASE = 8'h00;
	localparam logic [7:0]      PRM_RSV_BASE = 8'h10;
	localparam logic [7:0]      PRM_TBL_BASE = 8'h30;
	localparam logic [7:0]      PRM_END      = 8'h6f;
	// Header bytes 0x00..0x0f, index 0 at the right; count byte is zero-based
	localparam logic [15:0][7:0] PRM_HDR     = {8'hff, 8'h00, 8'h00, 8'h30,
	                                            8'h09, 8'h01, 8'h00, 8'h00,
	                                            8'hff, 8'h00, 8'h01, 8'h00,
	                                            8'h50, 8'h44, 8'h46, 8'h53};
	localparam logic [7:0]      PRM_TBL0     = 8'he5;
	localparam logic [7:0]      PRM_TBL1     = 8'h20;

	// Instruction codes
	localparam logic [7:0]      CMD_READ_PARAMS = 8'h5a;
	localparam logic [7:0]      CMD_READ        = 8'h03;
	localparam logic [7:0]      CMD_PROG        = 8'h02;
	localparam logic [7:0]      CMD_ERASE_SEC   = 8'h20;
	localparam logic [7:0]      CMD_ERASE_BLK   = 8'hd8;
	localparam logic [7:0]      CMD_ERASE_CHIP  = 8'hc7;
	localparam logic [7:0]      CMD_SR_READ     = 8'h48;
	localparam logic [7:0]      CMD_SR_PROG     = 8'h42;
	localparam logic [7:0]      CMD_SR_ERASE    = 8'h44;
	localparam logic [7:0]      CMD_SR_LOCK     = 8'h4c;

	// Reset values
	localparam logic [2:0]      LOCK_RST     = 3'h0;
	localparam logic [19:0]     ADDR_RST     = 20'h00000;
	localparam logic [7:0]      DATA_RST     = 8'h00;

	typedef enum logic [3:0] {
		OP_NONE, OP_READ, OP_PROG, OP_ERASE_SEC, OP_ERASE_BLK, OP_ERASE_CHIP,
		OP_SR_READ, OP_SR_PROG, OP_SR_ERASE, OP_SR_LOCK, OP_PARAM_READ
	} fsr_op_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_FETCH = 3'b001,
		ST_WAIT  = 3'b011,
		ST_MERGE = 3'b010,
		ST_ERASE = 3'b110
	} fsr_state_t;

	typedef enum logic [1:0] {TGT_MAIN, TGT_SEC, TGT_PARAM} fsr_tgt_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  instr;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} fsr_req_t;

	typedef struct packed {
		logic        done;
		logic        err;
		logic [7:0]  rdata;
	} fsr_rsp_t;

	typedef struct packed {
		logic [3:0]  blk;
		logic [7:0]  sec;
		logic [11:0] page;
		logic [11:0] in_sec;
	} fsr_loc_t;

endpackage

// file: hw/fsr_secreg_mem.sv
// Storage for the three writable security registers
`timescale 1ns/1ps
module fsr_secreg_mem (
	input  wire logic       clk,      // System clock
	input  wire logic       reset_n,  // Asynchronous reset, active low
	input  wire logic       ce,       // Clock enable
	input  wire logic       rd_en,    // Read strobe
	input  wire logic       wr_en,    // Write strobe
	input  wire logic [1:0] sel,      // Register number, 1 to 3
	input  wire logic [7:0] idx,      // Byte within the register
	input  wire logic [7:0] wdata,    // Write data
	output logic      [7:0] rdata     // Read data, one cycle after rd_en
);

	logic [7:0] mem [0:fsr_pkg::SR_WORDS-1];
	logic [7:0] rdata_d;
	logic [9:0] waddr;
	logic [1:0] bank;

	// Register 1 maps to the bottom of the array
	assign bank  = sel - 2'd1;
	assign waddr = {bank, idx};

	// Read data next value
	always_comb begin
		rdata_d = rdata;
		if (rd_en) begin
			rdata_d = mem[waddr];
		end
	end

	// Array write and read register
	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= fsr_pkg::DATA_RST;
		end else if (ce) begin
			rdata <= rdata_d;
		end
	end

endmodule

// file: hw/fsr_flash_map.sv
// Address decode and access sequencer for flash array, security registers and parameters
`timescale 1ns/1ps
module fsr_flash_map (
	input  wire logic              clk,        // System clock, 100 MHz
	input  wire logic              reset_n,    // Asynchronous reset, active low
	input  wire logic              ce,         // Clock enable, freezes state when low
	input  wire fsr_pkg::fsr_req_t req,        // Decoded instruction request
	output fsr_pkg::fsr_rsp_t      rsp,        // Completion pulse, error and read data
	output logic                   req_ready,  // Sequencer idle, request may be taken
	output fsr_pkg::fsr_loc_t      loc,        // Decoded position of last array access
	input  wire logic [2:0]        lock_nv,    // Stored lock bits for registers 1 to 3
	output logic      [2:0]        lock,       // Lock bits for registers 1 to 3
	output logic      [19:0]       arr_addr,   // Main array byte address
	output logic                   arr_rd,     // Main array read strobe
	output logic                   arr_wr,     // Main array write strobe
	output logic      [7:0]        arr_wdata,  // Main array write data
	input  wire logic [7:0]        arr_rdata   // Main array data, one cycle after arr_rd
);

	fsr_pkg::fsr_state_t st_q, st_d;
	fsr_pkg::fsr_op_t    op_q, op_d, op_w;
	fsr_pkg::fsr_tgt_t   tgt_q, tgt_d;
	fsr_pkg::fsr_rsp_t   rsp_d;
	fsr_pkg::fsr_loc_t   loc_d;
	logic [19:0]         arr_addr_d;
	logic [19:0]         end_q, end_d;
	logic [7:0]          arr_wdata_d;
	logic [7:0]          wdata_q, wdata_d;
	logic                arr_rd_d, arr_wr_d;
	logic                sr_rd_q, sr_rd_d;
	logic                sr_wr_q, sr_wr_d;
	logic [1:0]          sreg_q, sreg_d;
	logic [2:0]          lock_d;
	logic                ready_d;
	logic [7:0]          sr_rdata;
	logic [7:0]          fetched;
	logic [1:0]          sr_sel_w;
	logic                sr_addr_ok;
	logic                sr_locked;
	logic                prm_addr_ok;

	// Instruction decode; only the listed codes start an operation
	function automatic fsr_pkg::fsr_op_t decode(input logic [7:0] code);
		unique case (code)
			fsr_pkg::CMD_READ_PARAMS: decode = fsr_pkg::OP_PARAM_READ;
			fsr_pkg::CMD_READ:        decode = fsr_pkg::OP_READ;
			fsr_pkg::CMD_PROG:        decode = fsr_pkg::OP_PROG;
			fsr_pkg::CMD_ERASE_SEC:   decode = fsr_pkg::OP_ERASE_SEC;
			fsr_pkg::CMD_ERASE_BLK:   decode = fsr_pkg::OP_ERASE_BLK;
			fsr_pkg::CMD_ERASE_CHIP:  decode = fsr_pkg::OP_ERASE_CHIP;
			fsr_pkg::CMD_SR_READ:     decode = fsr_pkg::OP_SR_READ;
			fsr_pkg::CMD_SR_PROG:     decode = fsr_pkg::OP_SR_PROG;
			fsr_pkg::CMD_SR_ERASE:    decode = fsr_pkg::OP_SR_ERASE;
			fsr_pkg::CMD_SR_LOCK:     decode = fsr_pkg::OP_SR_LOCK;
			default:                  decode = fsr_pkg::OP_NONE;
		endcase
	endfunction

	// Parameter space contents: header, reserved gap, basic table, reserved tail
	function automatic logic [7:0] param_byte(input logic [7:0] a);
		if (a < fsr_pkg::PRM_RSV_BASE) begin
			param_byte = fsr_pkg::PRM_HDR[a[3:0]];
		end else if (a < fsr_pkg::PRM_TBL_BASE) begin
			param_byte = fsr_pkg::ERASED;
		end else if (a == fsr_pkg::PRM_TBL_BASE) begin
			param_byte = fsr_pkg::PRM_TBL0;
		end else if (a == fsr_pkg::PRM_TBL_BASE + 8'd1) begin
			param_byte = fsr_pkg::PRM_TBL1;
		end else if (a <= fsr_pkg::PRM_END) begin
			param_byte = fsr_pkg::ERASED;
		end else begin
			param_byte = fsr_pkg::ERASED;
		end
	endfunction

	// Lock bit of a writable register, 1 to 3
	function automatic logic lock_q_bit(input logic [1:0] s);
		lock_q_bit = lock[s - 2'd1];
	endfunction

	// Request decode for the security and parameter spaces
	assign op_w        = decode(req.instr);
	assign sr_sel_w    = req.addr[fsr_pkg::SR_SEL_LSB +: 2];
	assign sr_addr_ok  = (req.addr[23:14] == 10'h000) && (req.addr[11:8] == 4'h0);
	assign sr_locked   = (sr_sel_w == 2'd0) || lock_q_bit(sr_sel_w);
	assign prm_addr_ok = (req.addr[23:8] == 16'h0000);

	// Byte fetched in the wait state, by target
	always_comb begin
		unique case (tgt_q)
			fsr_pkg::TGT_MAIN: fetched = arr_rdata;
			fsr_pkg::TGT_SEC:  fetched = sr_rdata;
			default:           fetched = param_byte(arr_addr[7:0]);
		endcase
	end

	// Sequencer next state
	always_comb begin
		st_d        = st_q;
		op_d        = op_q;
		tgt_d       = tgt_q;
		end_d       = end_q;
		wdata_d     = wdata_q;
		sreg_d      = sreg_q;
		loc_d       = loc;
		arr_addr_d  = arr_addr;
		arr_wdata_d = arr_wdata;
		arr_rd_d    = 1'b0;
		arr_wr_d    = 1'b0;
		sr_rd_d     = 1'b0;
		sr_wr_d     = 1'b0;
		rsp_d       = rsp;
		rsp_d.done  = 1'b0;
		lock_d      = lock | lock_nv;
		unique case (st_q)
			fsr_pkg::ST_IDLE: begin
				if (req.valid) begin
					op_d    = op_w;
					wdata_d = req.wdata;
					sreg_d  = sr_sel_w;
					unique case (op_w)
						fsr_pkg::OP_READ, fsr_pkg::OP_PROG: begin
							tgt_d      = fsr_pkg::TGT_MAIN;
							arr_addr_d = req.addr[19:0];
							arr_rd_d   = 1'b1;
							st_d       = fsr_pkg::ST_FETCH;
						end
						fsr_pkg::OP_ERASE_SEC: begin
							tgt_d      = fsr_pkg::TGT_MAIN;
							arr_addr_d = req.addr[19:0] & ~fsr_pkg::SEC_MASK;
							end_d      = req.addr[19:0] | fsr_pkg::SEC_MASK;
							st_d       = fsr_pkg::ST_ERASE;
						end
						fsr_pkg::OP_ERASE_BLK: begin
							tgt_d      = fsr_pkg::TGT_MAIN;
							arr_addr_d = req.addr[19:0] & ~fsr_pkg::BLK_MASK;
							end_d      = req.addr[19:0] | fsr_pkg::BLK_MASK;
							st_d       = fsr_pkg::ST_ERASE;
						end
						fsr_pkg::OP_ERASE_CHIP: begin
							tgt_d      = fsr_pkg::TGT_MAIN;
							arr_addr_d = fsr_pkg::ADDR_RST;
							end_d      = fsr_pkg::CHIP_MASK;
							st_d       = fsr_pkg::ST_ERASE;
						end
						fsr_pkg::OP_SR_READ: begin
							if (!sr_addr_ok) begin
								rsp_d.done = 1'b1;
								rsp_d.err  = 1'b1;
							end else if (sr_sel_w == 2'd0) begin
								tgt_d      = fsr_pkg::TGT_PARAM;
								arr_addr_d = {12'h000, req.addr[7:0]};
								st_d       = fsr_pkg::ST_FETCH;
							end else begin
								tgt_d      = fsr_pkg::TGT_SEC;
								arr_addr_d = {12'h000, req.addr[7:0]};
								sr_rd_d    = 1'b1;
								st_d       = fsr_pkg::ST_FETCH;
							end
						end
						fsr_pkg::OP_SR_PROG: begin
							if (!sr_addr_ok || sr_locked) begin
								rsp_d.done = 1'b1;
								rsp_d.err  = 1'b1;
							end else begin
								tgt_d      = fsr_pkg::TGT_SEC;
								arr_addr_d = {12'h000, req.addr[7:0]};
								sr_rd_d    = 1'b1;
								st_d       = fsr_pkg::ST_FETCH;
							end
						end
						fsr_pkg::OP_SR_ERASE: begin
							if (!sr_addr_ok || sr_locked) begin
								rsp_d.done = 1'b1;
								rsp_d.err  = 1'b1;
							end else begin
								tgt_d       = fsr_pkg::TGT_SEC;
								arr_addr_d  = fsr_pkg::ADDR_RST;
								end_d       = {12'h000, fsr_pkg::SR_LAST};
								arr_wdata_d = fsr_pkg::ERASED;
								sr_wr_d     = 1'b1;
								st_d        = fsr_pkg::ST_ERASE;
							end
						end
						fsr_pkg::OP_SR_LOCK: begin
							rsp_d.done = 1'b1;
							rsp_d.err  = !sr_addr_ok;
							if (sr_addr_ok && sr_sel_w != 2'd0) begin
								lock_d[sr_sel_w - 2'd1] = 1'b1;
							end
						end
						fsr_pkg::OP_PARAM_READ: begin
							if (!prm_addr_ok) begin
								rsp_d.done = 1'b1;
								rsp_d.err  = 1'b1;
							end else begin
								tgt_d      = fsr_pkg::TGT_PARAM;
								arr_addr_d = {12'h000, req.addr[7:0]};
								st_d       = fsr_pkg::ST_FETCH;
							end
						end
						default: begin
							rsp_d.done = 1'b1; // No page erase or unknown code
							rsp_d.err  = 1'b1;
						end
					endcase
					if (op_w inside {fsr_pkg::OP_READ, fsr_pkg::OP_PROG, fsr_pkg::OP_ERASE_SEC,
					                 fsr_pkg::OP_ERASE_BLK, fsr_pkg::OP_ERASE_CHIP}) begin
						loc_d.blk    = req.addr[fsr_pkg::BLK_LSB +: 4];
						loc_d.sec    = req.addr[fsr_pkg::SEC_LSB +: 8];
						loc_d.page   = req.addr[fsr_pkg::PAGE_LSB +: 12];
						loc_d.in_sec = req.addr[11:0];
					end
					if (op_w inside {fsr_pkg::OP_ERASE_SEC, fsr_pkg::OP_ERASE_BLK,
					                 fsr_pkg::OP_ERASE_CHIP}) begin
						arr_wdata_d = fsr_pkg::ERASED;
						arr_wr_d    = 1'b1;
					end
				end
			end
			fsr_pkg::ST_FETCH: begin
				st_d = fsr_pkg::ST_WAIT;
			end
			fsr_pkg::ST_WAIT: begin
				if (op_q == fsr_pkg::OP_PROG || op_q == fsr_pkg::OP_SR_PROG) begin
					arr_wdata_d = fetched & wdata_q;
					arr_wr_d    = (tgt_q == fsr_pkg::TGT_MAIN);
					sr_wr_d     = (tgt_q == fsr_pkg::TGT_SEC);
					st_d        = fsr_pkg::ST_MERGE;
				end else begin
					rsp_d.done  = 1'b1;
					rsp_d.err   = 1'b0;
					rsp_d.rdata = fetched;
					st_d        = fsr_pkg::ST_IDLE;
				end
			end
			fsr_pkg::ST_MERGE: begin
				rsp_d.done = 1'b1;
				rsp_d.err  = 1'b0;
				st_d       = fsr_pkg::ST_IDLE;
			end
			fsr_pkg::ST_ERASE: begin
				if (arr_addr == end_q) begin
					rsp_d.done = 1'b1;
					rsp_d.err  = 1'b0;
					st_d       = fsr_pkg::ST_IDLE;
				end else begin
					arr_addr_d = arr_addr + 20'd1;
					arr_wr_d   = (tgt_q == fsr_pkg::TGT_MAIN);
					sr_wr_d    = (tgt_q == fsr_pkg::TGT_SEC);
				end
			end
			default: begin
				st_d = fsr_pkg::ST_IDLE;
			end
		endcase
		ready_d = (st_d == fsr_pkg::ST_IDLE);
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q      <= fsr_pkg::ST_IDLE;
			op_q      <= fsr_pkg::OP_NONE;
			tgt_q     <= fsr_pkg::TGT_MAIN;
			end_q     <= fsr_pkg::ADDR_RST;
			wdata_q   <= fsr_pkg::DATA_RST;
			sreg_q    <= 2'd0;
			loc       <= '0;
			arr_addr  <= fsr_pkg::ADDR_RST;
			arr_wdata <= fsr_pkg::DATA_RST;
			arr_rd    <= 1'b0;
			arr_wr    <= 1'b0;
			sr_rd_q   <= 1'b0;
			sr_wr_q   <= 1'b0;
			rsp       <= '0;
			lock      <= fsr_pkg::LOCK_RST;
			req_ready <= 1'b1;
		end else if (ce) begin
			st_q      <= st_d;
			op_q      <= op_d;
			tgt_q     <= tgt_d;
			end_q     <= end_d;
			wdata_q   <= wdata_d;
			sreg_q    <= sreg_d;
			loc       <= loc_d;
			arr_addr  <= arr_addr_d;
			arr_wdata <= arr_wdata_d;
			arr_rd    <= arr_rd_d;
			arr_wr    <= arr_wr_d;
			sr_rd_q   <= sr_rd_d;
			sr_wr_q   <= sr_wr_d;
			rsp       <= rsp_d;
			lock      <= lock_d;
			req_ready <= ready_d;
		end
	end

	// Writable security registers; register 0 is never addressed here
	fsr_secreg_mem u_secreg (
		.clk     (clk),
		.reset_n (reset_n),
		.ce      (ce),
		.rd_en   (sr_rd_q),
		.wr_en   (sr_wr_q),
		.sel     (sreg_q),
		.idx     (arr_addr[7:0]),
		.wdata   (arr_wdata),
		.rdata   (sr_rdata)
	);

endmodule

// file: verif/fsr_array_model.sv
// Behavioural main-array macro answering the sequencer's strobes
`timescale 1ns/1ps
module fsr_array_model (
	input  wire logic        clk,        // System clock
	input  wire logic [19:0] arr_addr,   // Byte address
	input  wire logic        arr_rd,     // Read strobe
	input  wire logic        arr_wr,     // Write strobe
	input  wire logic [7:0]  arr_wdata,  // Write data
	output logic      [7:0]  arr_rdata   // Read data, valid one cycle after arr_rd
);
	logic [7:0] mem [int];

	initial arr_rdata = 8'h5a;

	// Unwritten bytes read as erased; data outside a read cycle is scrambled so stale use shows
	always @(posedge clk) begin
		if (arr_wr)
			mem[arr_addr] = arr_wdata;
		if (arr_rd)
			arr_rdata <= mem.exists(arr_addr) ? mem[arr_addr] : 8'hff;
		else
			arr_rdata <= ~arr_rdata;
	end
endmodule

// file: verif/fsr_flash_map_properties.sv
// Concurrent checks on the flash map sequencer ports
`timescale 1ns/1ps
module fsr_flash_map_chk (
	input wire logic              clk,        // System clock
	input wire logic              reset_n,    // Reset, active low
	input wire logic              ce,         // Clock enable
	input wire fsr_pkg::fsr_req_t req,        // Request
	input wire fsr_pkg::fsr_rsp_t rsp,        // Response
	input wire logic              req_ready,  // Sequencer idle
	input wire logic [2:0]        lock_nv,    // Stored lock bits
	input wire logic [2:0]        lock,       // Sticky lock bits
	input wire logic [19:0]       arr_addr,   // Array address
	input wire logic              arr_rd,     // Array read strobe
	input wire logic              arr_wr,     // Array write strobe
	input wire logic [7:0]        arr_wdata,  // Array write data
	input wire logic [7:0]        arr_rdata   // Array read data
);
	logic take;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Request accepted on this edge
	assign take = ce && req.valid && req_ready;

	property p_rd_addr;
		take && req.instr == 8'h03 |=> arr_rd && arr_addr == $past(req.addr[19:0]);
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("read strobe or address wrong");
	property p_rd_done;
		take && req.instr == 8'h03 ##1 ce [*3] |-> rsp.done;
	endproperty
	a_rd_done: assert property (p_rd_done) else $error("read answer late");
	property p_prog_and;
		take && req.instr == 8'h02 ##1 ce [*2] |=>
			arr_wr && arr_wdata == ($past(arr_rdata) & $past(req.wdata, 3));
	endproperty
	a_prog_and: assert property (p_prog_and) else $error("program sets bits");
	property p_erase_wr;
		take && req.instr == 8'h20 |=>
			arr_wr && arr_wdata == 8'hff && arr_addr == {$past(req.addr[19:12]), 12'h000};
	endproperty
	a_erase_wr: assert property (p_erase_wr) else $error("erase start wrong");
	property p_erase_step;
		arr_wr && $past(arr_wr) && $past(ce) |-> arr_addr == $past(arr_addr) + 20'h1;
	endproperty
	a_erase_step: assert property (p_erase_step) else $error("erase address skips");
	property p_ready_busy;
		take && req.instr == 8'h20 |=> !req_ready [*8];
	endproperty
	a_ready_busy: assert property (p_ready_busy) else $error("ready during erase");
	property p_lock_sticky;
		($past(lock) & ~lock) == 3'h0;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");
	property p_lock_nv;
		ce |=> (lock & $past(lock_nv)) == $past(lock_nv);
	endproperty
	a_lock_nv: assert property (p_lock_nv) else $error("stored lock not taken");
	property p_sec0_ro;
		take && req.instr == 8'h42 && req.addr[13:12] == 2'h0 |=> rsp.done && rsp.err && !arr_wr;
	endproperty
	a_sec0_ro: assert property (p_sec0_ro) else $error("register 0 program taken");
	property p_param_sep;
		take && req.instr == 8'h5a |=> !arr_rd [*3];
	endproperty
	a_param_sep: assert property (p_param_sep) else $error("parameter read hit array");

	// Main scenarios reached
	c_param: cover property (take && req.instr == 8'h5a);
	c_sec_erase: cover property (take && req.instr == 8'h44);
	c_blk_erase: cover property (take && req.instr == 8'hd8);
endmodule

bind fsr_flash_map fsr_flash_map_chk u_chk (.clk(clk), .reset_n(reset_n), .ce(ce), .req(req),
	.rsp(rsp), .req_ready(req_ready), .lock_nv(lock_nv), .lock(lock), .arr_addr(arr_addr),
	.arr_rd(arr_rd), .arr_wr(arr_wr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata));

// file: verif/testbench.sv
// Self-checking bench for the flash map sequencer
`timescale 1ns/1ps
module testbench;
	logic              clk, reset_n, ce, req_ready, arr_rd, arr_wr;
	fsr_pkg::fsr_req_t req;
	fsr_pkg::fsr_rsp_t rsp;
	fsr_pkg::fsr_loc_t loc;
	logic [2:0]        lock_nv, lock;
	logic [19:0]       arr_addr;
	logic [7:0]        arr_wdata, arr_rdata;
	logic [7:0]        mem [int];
	logic [7:0]        sr [4][256];
	int                num_errors, total_checks;
	localparam logic [7:0] HDR [16] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hff,
		8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff};

	fsr_flash_map dut (.clk(clk), .reset_n(reset_n), .ce(ce), .req(req), .rsp(rsp),
		.req_ready(req_ready), .loc(loc), .lock_nv(lock_nv), .lock(lock), .arr_addr(arr_addr),
		.arr_rd(arr_rd), .arr_wr(arr_wr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata));
	fsr_array_model u_arr (.clk(clk), .arr_addr(arr_addr), .arr_rd(arr_rd), .arr_wr(arr_wr),
		.arr_wdata(arr_wdata), .arr_rdata(arr_rdata));

	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Expected parameter-space byte
	function automatic logic [7:0] prm(int i);
		return i < 16 ? HDR[i] : i == 'h30 ? 8'he5 : i == 'h31 ? 8'h20 : 8'hff;
	endfunction
	function automatic logic [7:0] mget(logic [19:0] a);
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction

	task tally_and_finish;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input logic [35:0] got, input logic [35:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One request; answer latency, error flag and read data compared with the model
	task op(input logic [7:0] ins, input logic [23:0] a, input logic [7:0] wd, input int lat,
		input logic e_err, input logic [7:0] e_rd);
		int n;
		@(posedge clk);
		req <= '{1'b1, ins, a, wd};
		@(posedge clk);
		req <= '{1'b0, 8'h00, ~a, ~wd};
		// The taking edge counts as one; a refused answer stands only after it
		n = 1;
		#1;
		while (rsp.done !== 1'b1 && n < 70000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 70000) begin
			chk(36'h0, 36'h1, "answer timeout");
			tally_and_finish;
		end else begin
			chk(36'(n), 36'(lat), "latency");
			chk(36'(rsp.err), 36'(e_err), "error flag");
			if ((ins == 8'h03 || ins == 8'h48 || ins == 8'h5a) && !e_err)
				chk(36'(rsp.rdata), 36'(e_rd), "read data");
		end
	endtask

	task rd(input logic [23:0] a);
		op(8'h03, a, 8'h00, 3, 1'b0, mget(a[19:0]));
	endtask
	task pg(input logic [23:0] a, input logic [7:0] d);
		op(8'h02, a, d, 4, 1'b0, 8'h00);
		mem[a[19:0]] = mget(a[19:0]) & d;
	endtask
	task er(input logic [7:0] ins, input logic [23:0] a, input int sz);
		logic [19:0] base;
		base = a[19:0] & ~20'(sz - 1);
		op(ins, a, 8'h00, sz + 1, 1'b0, 8'h00);
		for (int j = 0; j < sz; j++)
			mem[base + 20'(j)] = 8'hff;
	endtask

	// Main sequence
	initial begin
		int i, k;
		logic [23:0] a;
		logic [7:0] d;
		num_errors = 0;
		total_checks = 0;
		reset_n = 1'b0;
		ce = 1'b1;
		lock_nv = 3'h0;
		req = '0;
		void'($urandom(44007));
		for (k = 0; k < 256; k++)
			sr[0][k] = prm(k);
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		for (i = 0; i < 256; i++) begin
			if (i < 16)
				op(8'h5a, 24'(i), 8'h00, 3, 1'b0, prm(i));
			else
				op(8'h5a, 24'(i), 8'h00, 3, 1'b0, prm(i));
		end
		for (i = 0; i < 256; i += 5) op(8'h48, 24'(i), 8'h00, 3, 1'b0, sr[0][i]);
		op(8'h5a, 24'h000100, 8'h00, 1, 1'b1, 8'h00);
		op(8'h11, 24'h000000, 8'h00, 1, 1'b1, 8'h00);
		op(8'h42, 24'h000010, 8'h55, 1, 1'b1, 8'h00);
		op(8'h44, 24'h000000, 8'h00, 1, 1'b1, 8'h00);
		op(8'h4c, 24'h000000, 8'h00, 1, 1'b0, 8'h00);
		for (i = 0; i < 8; i++) begin
			a = 24'($urandom);
			pg(a, 8'($urandom));
			pg(a, 8'($urandom));
			rd(a);
			chk(loc, {a[19:16], a[19:12], a[19:8], a[11:0]}, "location");
		end
		// Sector and block erase leave neighbours untouched
		a = 24'($urandom) & 24'h0fffff;
		pg(a, 8'h00);
		pg({a[23:12], 12'hfff}, 8'h00);
		pg(a ^ 24'h001000, 8'h00);
		er(8'h20, a, 4096);
		rd({a[23:12], 12'h000});
		rd({a[23:12], 12'hfff});
		rd(a ^ 24'h001000);
		pg(a, 8'h00);
		pg(a ^ 24'h010000, 8'h00);
		er(8'hd8, a, 65536);
		rd(a);
		rd(a ^ 24'h010000);
		// Clock enable low while the read strobe stands stalls the answer by three cycles
		fork
			op(8'h03, a, 8'h00, 6, 1'b0, mget(a[19:0]));
			begin
				repeat (2) @(posedge clk);
				ce <= 1'b0;
				repeat (3) @(posedge clk);
				ce <= 1'b1;
			end
		join
		// Security registers
		for (k = 1; k < 4; k++) begin
			op(8'h44, 24'(k) << 12, 8'h00, 257, 1'b0, 8'h00);
			for (i = 0; i < 256; i++)
				sr[k][i] = 8'hff;
			d = 8'($urandom);
			op(8'h42, (24'(k) << 12) | 24'h0000ff, d, 4, 1'b0, 8'h00);
			sr[k][255] = d;
			op(8'h48, (24'(k) << 12) | 24'h0000ff, 8'h00, 3, 1'b0, sr[k][255]);
		end
		op(8'h4c, 24'h001000, 8'h00, 1, 1'b0, 8'h00);
		op(8'h42, 24'h001000, 8'h00, 1, 1'b1, 8'h00);
		op(8'h44, 24'h001000, 8'h00, 1, 1'b1, 8'h00);
		op(8'h48, 24'h0010ff, 8'h00, 3, 1'b0, sr[1][255]);
		op(8'h42, 24'h002000, 8'h00, 4, 1'b0, 8'h00);
		op(8'h48, 24'h002000, 8'h00, 3, 1'b0, 8'h00);
		op(8'h48, 24'h001100, 8'h00, 1, 1'b1, 8'h00);
		@(posedge clk);
		lock_nv <= 3'h4;
		op(8'h42, 24'h0030ff, 8'h00, 1, 1'b1, 8'h00);
		chk(lock, 3'h5, "lock bits");
		@(posedge clk);
		lock_nv <= 3'h0;
		repeat (3) @(posedge clk);
		#1;
		chk(lock, 3'h5, "lock bits kept");
		tally_and_finish;
	end
endmodule
